// *** verilog/sopm_regs.v ***
// sopm_regs.v: system option and supply monitor register bank
// assumes: Avalon-MM word slave on clk; supply comparators asynchronous
`default_nettype none
`include "sopm_map.vh"
// Function
// - bit7 write-once selects watchdog clock
// - window service in last quarter
// - early service write forces reset
// - window only with bus clock
// - bit4 links comparator to capture
// - bit3 moves timer2 channel1 pin
// - bit2 moves timer2 channel0 pin
// - bit1 moves timer1 channel1 pin
// - write-once bits take first write
// - fixed 12-bit part number, read-only
// - reserved id bits ignore writes
// - bit7 id high fixed series marker
// - warning flag sets and sticks
// - ack clears flag only when healthy
// - interrupt while flag and enable
// - detect reset when enabled
// - detect keeps running in stop
// - detect enable qualifies other bits
// - bit0 drives bandgap buffer enable
// - timeout from select bits and clock
module sopm_regs (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        supply_warn_in,
    input  wire        supply_detect_in,
    input  wire        stop_mode,
    input  wire        comparator_out,
    output reg         capture_ch0_in,
    output reg         timer2_ch1_pin_select,
    output reg         timer2_ch0_pin_select,
    output reg         timer1_ch1_pin_select,
    output reg         timer1_ch0_pin_select,
    output reg         supply_warning_irq,
    output reg         mcu_reset_req,
    output reg         undervolt_detect_active,
    output reg         bandgap_buffer_enable,
    output reg         watchdog_running
);
    reg  [7:0] opt2;
    reg  [7:0] opt1;
    reg  [7:0] pmc1;
    reg        opt2_locked;
    reg        opt1_locked;
    reg        pmc1_locked;
    reg        acked;
    reg        svc_wr;
    reg  [7:0] svc_data;
    reg  [7:0] rd_byte;
    wire       warn_s;
    wire       detect_s;
    wire       wd_reset;
    wire       wd_active;
    wire       wr_lane0;
    wire [7:0] wbyte;
    wire       det_on;

    localparam [11:0] PART_NUM = `SOPM_PART_NUM;

    assign wbyte    = avs_writedata[7:0];
    assign wr_lane0 = avs_write & avs_byteenable[0] & ~avs_waitrequest;

    sopm_sync u_sync_warn (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (supply_warn_in),
        .q     (warn_s)
    );

    sopm_sync u_sync_det (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (supply_detect_in),
        .q     (detect_s)
    );

    sopm_wdog u_wdog (
        .clk       (clk),
        .rst_n     (rst_n),
        .clk_sel   (opt2[`SOPM_OPT2_WDCLK]),
        .win_en    (opt2[`SOPM_OPT2_WDWIN]),
        .to_sel    (opt1[`SOPM_OPT1_TO_HI:`SOPM_OPT1_TO_LO]),
        .svc_wr    (svc_wr),
        .svc_data  (svc_data),
        .wd_reset  (wd_reset),
        .wd_active (wd_active)
    );

    assign det_on = pmc1[`SOPM_PMC1_DEN] & (~stop_mode | pmc1[`SOPM_PMC1_DSTOP]);

    // bus handshake: one wait cycle then accept
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
        end
    end

    always @* begin
        case (avs_address)
            `SOPM_ADDR_OPT2:  rd_byte = opt2;
            `SOPM_ADDR_IDH:   rd_byte = {`SOPM_SERIES_BIT, `SOPM_RSVD_BITS, PART_NUM[11:8]};
            `SOPM_ADDR_IDL:   rd_byte = PART_NUM[7:0];
            `SOPM_ADDR_PMC1:  rd_byte = {pmc1[7], 1'b0, pmc1[5:0]};
            `SOPM_ADDR_OPT1:  rd_byte = opt1;
            `SOPM_ADDR_STAT:  rd_byte = {6'h00, det_on, wd_active};
            default:          rd_byte = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt2        <= `SOPM_OPT2_RST;
            opt1        <= `SOPM_OPT1_RST;
            pmc1        <= `SOPM_PMC1_RST;
            opt2_locked <= 1'b0;
            opt1_locked <= 1'b0;
            pmc1_locked <= 1'b0;
            acked       <= 1'b0;
            svc_wr      <= 1'b0;
            svc_data    <= 8'h00;
        end else begin
            svc_wr   <= 1'b0;
            acked    <= 1'b0;
            if (wr_lane0) begin
                case (avs_address)
                    `SOPM_ADDR_OPT2: begin
                        if (!opt2_locked) begin
                            opt2[7:6] <= wbyte[7:6];
                        end
                        opt2_locked <= 1'b1;
                        opt2[4:0] <= wbyte[4:0];
                    end
                    `SOPM_ADDR_OPT1: begin
                        if (!opt1_locked) begin
                            opt1 <= wbyte;
                        end
                        opt1_locked <= 1'b1;
                    end
                    `SOPM_ADDR_PMC1: begin
                        if (!pmc1_locked) begin
                            pmc1[4:2] <= wbyte[4:2];
                        end
                        pmc1_locked <= 1'b1;
                        pmc1[`SOPM_PMC1_WIRQ]  <= wbyte[5];
                        pmc1[`SOPM_PMC1_BGBUF] <= wbyte[0];
                        acked                  <= wbyte[6];
                    end
                    `SOPM_ADDR_WDSVC: begin
                        svc_wr   <= 1'b1;
                        svc_data <= wbyte;
                    end
                    default: begin
                    end
                endcase
            end
            if (warn_s) begin
                pmc1[`SOPM_PMC1_WFLAG] <= 1'b1;
            end else if (acked) begin
                pmc1[`SOPM_PMC1_WFLAG] <= 1'b0;
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_ch0_in          <= 1'b0;
            timer2_ch1_pin_select   <= 1'b0;
            timer2_ch0_pin_select   <= 1'b0;
            timer1_ch1_pin_select   <= 1'b0;
            timer1_ch0_pin_select   <= 1'b0;
            supply_warning_irq      <= 1'b0;
            mcu_reset_req           <= 1'b0;
            undervolt_detect_active <= 1'b0;
            bandgap_buffer_enable   <= 1'b0;
            watchdog_running        <= 1'b0;
        end else begin
            capture_ch0_in        <= opt2[`SOPM_OPT2_ACLINK] & comparator_out;
            timer2_ch1_pin_select <= opt2[`SOPM_OPT2_T2C1];
            timer2_ch0_pin_select <= opt2[`SOPM_OPT2_T2C0];
            timer1_ch1_pin_select <= opt2[`SOPM_OPT2_T1C1];
            timer1_ch0_pin_select <= opt2[`SOPM_OPT2_T1C0];
            supply_warning_irq    <= pmc1[`SOPM_PMC1_WFLAG] & pmc1[`SOPM_PMC1_WIRQ];
            mcu_reset_req         <= wd_reset | (det_on & pmc1[`SOPM_PMC1_DRST] & detect_s);
            undervolt_detect_active <= det_on;
            bandgap_buffer_enable <= pmc1[`SOPM_PMC1_BGBUF];
            watchdog_running      <= wd_active;
        end
    end
endmodule
`default_nettype wire

// *** verilog/sopm_map.vh ***
// sopm_map.vh: offsets, field positions, reset values and timing for the option bank
// assumes: included by the option bank modules, word-addressed Avalon-MM slave
`ifndef SOPM_MAP_VH
`define SOPM_MAP_VH

// register word addresses
`define SOPM_ADDR_OPT2      4'h0
`define SOPM_ADDR_IDH       4'h1
`define SOPM_ADDR_IDL       4'h2
`define SOPM_ADDR_PMC1      4'h3
`define SOPM_ADDR_OPT1      4'h4
`define SOPM_ADDR_WDSVC     4'h5
`define SOPM_ADDR_STAT      4'h6

// system_options_two fields
`define SOPM_OPT2_WDCLK     7
`define SOPM_OPT2_WDWIN     6
`define SOPM_OPT2_ACLINK    4
`define SOPM_OPT2_T2C1      3
`define SOPM_OPT2_T2C0      2
`define SOPM_OPT2_T1C1      1
`define SOPM_OPT2_T1C0      0

// system_options_one fields
`define SOPM_OPT1_TO_HI     7
`define SOPM_OPT1_TO_LO     6

// power_monitor_control_one fields
`define SOPM_PMC1_WFLAG     7
`define SOPM_PMC1_WACK      6
`define SOPM_PMC1_WIRQ      5
`define SOPM_PMC1_DRST      4
`define SOPM_PMC1_DSTOP     3
`define SOPM_PMC1_DEN       2
`define SOPM_PMC1_BGBUF     0

// reset values
`define SOPM_OPT2_RST       8'h00
`define SOPM_OPT1_RST       8'hc0
`define SOPM_PMC1_RST       8'h1c

// identification: values arbitrary
`define SOPM_SERIES_BIT     1'b1
`define SOPM_PART_NUM       12'h0_5c3
`define SOPM_RSVD_BITS      3'h0

// service sequence bytes
`define SOPM_SVC_FIRST      8'h55
`define SOPM_SVC_SECOND     8'haa

// watchdog periods in source ticks, indexed by timeout select
`define SOPM_WD_T1          32'h0000_0020
`define SOPM_WD_T2          32'h0000_0100
`define SOPM_WD_T3          32'h0000_0400
`define SOPM_SLOW_KHZ       32'h0000_0001
`define SOPM_CLK_KHZ        32'h0001_86a0
`define SOPM_SLOW_DIV       (`SOPM_CLK_KHZ / `SOPM_SLOW_KHZ)

`endif

// *** verilog/sopm_sync.v ***
// sopm_sync.v: two-flop level synchroniser
// assumes: d comes from outside the clk domain
`default_nettype none
module sopm_sync (
    input  wire clk,
    input  wire rst_n,
    input  wire d,
    output reg  q
);
    reg meta;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// *** verilog/sopm_wdog.v ***
// sopm_wdog.v: watchdog counter with optional service window
// assumes: service strobes are one-cycle pulses on clk; slow tick divided here
`default_nettype none
`include "sopm_map.vh"
module sopm_wdog #(
    parameter [31:0] SLOW_DIV = `SOPM_SLOW_DIV
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       clk_sel,
    input  wire       win_en,
    input  wire [1:0] to_sel,
    input  wire       svc_wr,
    input  wire [7:0] svc_data,
    output reg        wd_reset,
    output reg        wd_active
);
    reg  [31:0] div_cnt;
    reg  [31:0] cnt;
    reg         armed;
    wire        tick;
    wire [31:0] period;
    wire        win_mode;

    function [31:0] wd_period;
        input [1:0] sel;
        begin
            case (sel)
                2'd1:    wd_period = `SOPM_WD_T1;
                2'd2:    wd_period = `SOPM_WD_T2;
                2'd3:    wd_period = `SOPM_WD_T3;
                default: wd_period = 32'h0000_0000;
            endcase
        end
    endfunction

    assign period = wd_period(to_sel);
    assign tick   = clk_sel | (div_cnt == SLOW_DIV - 32'd1);
    assign win_mode = win_en & clk_sel;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt   <= 32'h0000_0000;
            cnt       <= 32'h0000_0000;
            armed     <= 1'b0;
            wd_reset  <= 1'b0;
            wd_active <= 1'b0;
        end else begin
            wd_active <= (to_sel != 2'd0);
            div_cnt   <= (div_cnt == SLOW_DIV - 32'd1) ? 32'h0000_0000 : div_cnt + 32'd1;
            wd_reset  <= 1'b0;
            if (to_sel == 2'd0) begin
                cnt   <= 32'h0000_0000;
                armed <= 1'b0;
            end else if (svc_wr) begin
                if (win_mode && (cnt < period - (period >> 2))) begin
                    wd_reset <= 1'b1;
                end else if (svc_data == `SOPM_SVC_FIRST) begin
                    armed <= 1'b1;
                end else if (armed && svc_data == `SOPM_SVC_SECOND) begin
                    armed <= 1'b0;
                    cnt   <= 32'h0000_0000;
                end else begin
                    armed <= 1'b0;
                end
            end else if (tick) begin
                if (cnt >= period - 32'd1) begin
                    wd_reset <= 1'b1;
                    cnt      <= 32'h0000_0000;
                end else begin
                    cnt <= cnt + 32'd1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** test/sopm_regs_asserts.sv ***
// sopm_regs_asserts.sv: port checks for the option bank
// assumes: bound to sopm_regs; one clock, reset async low
`default_nettype none
`include "sopm_map.vh"
module sopm_regs_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        supply_warn_in,
    input wire logic        comparator_out,
    input wire logic        capture_ch0_in,
    input wire logic        timer2_ch1_pin_select,
    input wire logic        timer2_ch0_pin_select,
    input wire logic        timer1_ch1_pin_select,
    input wire logic        timer1_ch0_pin_select,
    input wire logic        supply_warning_irq,
    input wire logic        bandgap_buffer_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] PN = `SOPM_PART_NUM;
    wire logic done = !avs_waitrequest && avs_byteenable[0];
    wire logic pm_wr = avs_write && done && avs_address == `SOPM_ADDR_PMC1;
    wire logic o2_wr = avs_write && done && avs_address == `SOPM_ADDR_OPT2;
    wire logic rd_ok = avs_read && !avs_waitrequest;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    cap_link_a: assert property (capture_ch0_in |-> $past(comparator_out))
        else $error("capture high without comparator");
    reset_outs_a: assert property ($rose(rst_n) |-> !bandgap_buffer_enable
        && !supply_warning_irq && !capture_ch0_in && !timer1_ch0_pin_select)
        else $error("output not cleared by reset");
    ack_guard_a: assert property (supply_warn_in[*4] ##0 (pm_wr
        && avs_writedata[6] && avs_writedata[5] && supply_warning_irq)
        |-> ##3 supply_warning_irq)
        else $error("warning cleared while supply low");
    warn_sticky_a: assert property (supply_warning_irq && !pm_wr && !$past(pm_wr)
        && !$past(pm_wr, 2) |=> supply_warning_irq)
        else $error("warning dropped without a write");
    irq_enable_a: assert property (pm_wr && !avs_writedata[5]
        |-> ##2 !supply_warning_irq)
        else $error("interrupt while disabled");
    id_low_a: assert property (rd_ok && avs_address == `SOPM_ADDR_IDL
        |-> avs_readdata[7:0] == PN[7:0])
        else $error("low id byte wrong");
    id_high_a: assert property (rd_ok && avs_address == `SOPM_ADDR_IDH
        |-> avs_readdata[7] == `SOPM_SERIES_BIT && avs_readdata[3:0] == PN[11:8])
        else $error("high id byte wrong");
    bgbuf_a: assert property (pm_wr
        |-> ##2 bandgap_buffer_enable == $past(avs_writedata[0], 2))
        else $error("bandgap enable not written");
    pin_sel_a: assert property (o2_wr |-> ##2 {timer2_ch1_pin_select,
        timer2_ch0_pin_select, timer1_ch1_pin_select, timer1_ch0_pin_select}
        == $past(avs_writedata[3:0], 2))
        else $error("pin select not written");
endmodule
bind sopm_regs sopm_regs_chk chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .supply_warn_in(supply_warn_in),
    .comparator_out(comparator_out), .capture_ch0_in(capture_ch0_in),
    .timer2_ch1_pin_select(timer2_ch1_pin_select),
    .timer2_ch0_pin_select(timer2_ch0_pin_select),
    .timer1_ch1_pin_select(timer1_ch1_pin_select),
    .timer1_ch0_pin_select(timer1_ch0_pin_select),
    .supply_warning_irq(supply_warning_irq), .bandgap_buffer_enable(bandgap_buffer_enable));
`default_nettype wire

// *** test/sopm_tb.sv ***
// sopm_tb.sv: register-level bench for the option and supply monitor bank
// assumes: sopm_regs and its checker compiled first; one 100 MHz clock
`default_nettype none
`include "sopm_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] PN = `SOPM_PART_NUM;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rdq = 1'b0;
    logic        wrq = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdata;
    logic        wait_q;
    logic        warn = 1'b0;
    logic        det = 1'b0;
    logic        stop = 1'b0;
    logic        cmp = 1'b0;
    logic        cap, t2c1, t2c0, t1c1, t1c0, irq, rreq, dact, bg, wdr;
    logic [7:0]  rd;
    int          err_total = 0;
    int          n_tests = 0;
    always #5 clk = ~clk;
    sopm_regs dut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rdq),
        .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(4'h1), .avs_readdata(rdata),
        .avs_waitrequest(wait_q), .supply_warn_in(warn), .supply_detect_in(det),
        .stop_mode(stop), .comparator_out(cmp), .capture_ch0_in(cap),
        .timer2_ch1_pin_select(t2c1), .timer2_ch0_pin_select(t2c0),
        .timer1_ch1_pin_select(t1c1), .timer1_ch0_pin_select(t1c0),
        .supply_warning_irq(irq), .mcu_reset_req(rreq), .undervolt_detect_active(dact),
        .bandgap_buffer_enable(bg), .watchdog_running(wdr));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one bus access: hold until waitrequest sampled low, then release
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        adr <= a;
        wd <= {24'h00_0000, d};
        wrq <= w;
        rdq <= ~w;
        @(posedge clk);
        while (wait_q !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_total++;
                summarize();
            end
            @(posedge clk);
        end
        rd = rdata[7:0];
        wrq <= 1'b0;
        rdq <= 1'b0;
        @(posedge clk);
    endtask
    // watch irq (s=1) or reset request (s=0) for a bounded span
    task automatic ev(input logic s, input logic e);
        logic seen;
        seen = 1'b0;
        repeat (12) begin
            @(posedge clk);
            seen = seen | (s ? irq : rreq);
        end
        chk({7'h00, seen}, {7'h00, e});
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    initial begin
        do_reset();
        acc(0, `SOPM_ADDR_OPT2, 8'h00); chk(rd, `SOPM_OPT2_RST);
        acc(0, `SOPM_ADDR_OPT1, 8'h00); chk(rd, `SOPM_OPT1_RST);
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk(rd, `SOPM_PMC1_RST);
        chk({7'h00, wdr}, 8'h01);
        acc(0, `SOPM_ADDR_STAT, 8'h00); chk(rd, 8'h03);
        acc(0, `SOPM_ADDR_IDL, 8'h00); chk(rd, PN[7:0]);
        acc(1, `SOPM_ADDR_IDH, 8'hff);
        acc(0, `SOPM_ADDR_IDH, 8'h00); chk(rd & 8'h8f, {`SOPM_SERIES_BIT, 3'h0, PN[11:8]});
        acc(0, 4'h7, 8'h00); chk(rd, 8'h00);
        acc(1, `SOPM_ADDR_PMC1, 8'h3d);
        acc(1, `SOPM_ADDR_PMC1, 8'h21);
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk(rd, 8'h3d);
        chk({7'h00, bg}, 8'h01);
        warn <= 1'b1;
        ev(1, 1);
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk(rd, 8'hbd);
        acc(1, `SOPM_ADDR_PMC1, 8'h61);
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk(rd, 8'hbd);
        warn <= 1'b0;
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk(rd, 8'hbd);
        acc(1, `SOPM_ADDR_PMC1, 8'h61);
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk(rd, 8'h3d);
        chk({7'h00, irq}, 8'h00);
        warn <= 1'b1;
        acc(1, `SOPM_ADDR_PMC1, 8'h01);
        ev(1, 0);
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk(rd, 8'h9d);
        warn <= 1'b0;
        stop <= 1'b1;
        acc(0, `SOPM_ADDR_PMC1, 8'h00); chk({7'h00, dact}, 8'h01);
        stop <= 1'b0;
        det <= 1'b1;
        ev(0, 1);
        det <= 1'b0;
        acc(1, `SOPM_ADDR_OPT1, 8'h00);
        repeat (2) @(posedge clk);
        chk({7'h00, wdr}, 8'h00);
        do_reset();
        acc(1, `SOPM_ADDR_PMC1, 8'h00);
        det <= 1'b1;
        ev(0, 0);
        chk({7'h00, dact}, 8'h00);
        det <= 1'b0;
        acc(1, `SOPM_ADDR_OPT2, 8'h40);
        acc(1, `SOPM_ADDR_WDSVC, `SOPM_SVC_FIRST);
        ev(0, 0);
        do_reset();
        acc(1, `SOPM_ADDR_OPT1, 8'h40);
        acc(1, `SOPM_ADDR_OPT2, 8'h80);
        ev(0, 0);
        acc(1, `SOPM_ADDR_WDSVC, `SOPM_SVC_FIRST);
        acc(1, `SOPM_ADDR_WDSVC, `SOPM_SVC_SECOND);
        ev(0, 0);
        ev(0, 0);
        ev(0, 1);
        do_reset();
        acc(1, `SOPM_ADDR_OPT2, 8'hdf);
        @(posedge clk);
        chk({4'h0, t2c1, t2c0, t1c1, t1c0}, 8'h0f);
        cmp <= 1'b1;
        acc(0, `SOPM_ADDR_OPT2, 8'h00); chk(rd, 8'hdf);
        chk({7'h00, cap}, 8'h01);
        acc(1, `SOPM_ADDR_OPT2, 8'h00);
        acc(0, `SOPM_ADDR_OPT2, 8'h00); chk(rd, 8'hc0);
        chk({3'h0, cap, t2c1, t2c0, t1c1, t1c0}, 8'h00);
        acc(1, `SOPM_ADDR_WDSVC, `SOPM_SVC_FIRST);
        ev(0, 1);
        summarize();
    end
endmodule
`default_nettype wire
